/* hdl/dvi_prio_enc.sv */
// fixed-priority selection of the next hardware vector
`timescale 1ns/1ps
`default_nettype none
module dvi_prio_enc
  import dvi_pkg::*;
(
  // requests in, choice out
  dvi_req_if.prio rq
);
  // index 0 is the most urgent maskable line
  localparam logic [NUM_MASKABLE-1:0][4:0] MASK_K = {K_TIMER, K_EXT_C, K_EXT_B, K_EXT_A};

  always_comb
  begin
    rq.pick_valid = 1'b1;
    rq.pick_k = K_RESET;
    rq.pick_clr = FLAGS_CLEAR;
    // reset 1, reserved slot 2 has no source, nmi 3
    if (rq.boot_pend)
      rq.pick_k = K_RESET;
    else if (rq.nmi_pend)
      rq.pick_k = K_NMI;
    else
    begin
      rq.pick_valid = |rq.enabled;
      // smallest priority number wins
      for (int i = NUM_MASKABLE - 1; i >= 0; i--)
      begin
        if (rq.enabled[i])
        begin
          rq.pick_k = MASK_K[i];
          rq.pick_clr = FLAGS_CLEAR;
          rq.pick_clr[i] = 1'b1;
        end
      end
    end
  end
endmodule
`default_nettype wire

/* hdl/dvi_req_capture.sv */
// pin synchronisers, falling-edge detection and reset pin combining
`timescale 1ns/1ps
`default_nettype none
module dvi_req_capture
  import dvi_pkg::*;
(
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rstn,
  // pins
  input wire logic i_hardware_reset_pin_n,
  input wire logic i_hardware_reset_pin,
  input wire logic i_nmi_n,
  input wire logic [2:0] i_ext_req_n,
  // towards core
  dvi_req_if.cap rq
);
  typedef struct packed {
    logic [NUM_PINS-1:0] s1;
    logic [NUM_PINS-1:0] s2;
    logic [NUM_EDGE-1:0] s3;
  } dvi_cap_t;

  localparam dvi_cap_t CAP_RST = '{s1: PIN_IDLE, s2: PIN_IDLE, s3: EDGE_IDLE};

  dvi_cap_t cap_r;
  dvi_cap_t cap_nxt;

  always_comb
  begin
    cap_nxt = cap_r;
    cap_nxt.s1 = {i_ext_req_n, i_nmi_n, i_hardware_reset_pin, i_hardware_reset_pin_n};
    cap_nxt.s2 = cap_r.s1;
    cap_nxt.s3 = cap_r.s2[NUM_PINS-1:PIN_NMI];
  end

  always_ff @(posedge i_mclk or negedge i_rstn)
  begin
    if (!i_rstn)
      cap_r <= CAP_RST;
    else
      cap_r <= cap_nxt;
  end

  // either reset pin asserts reset
  assign rq.rst_active = ~cap_r.s2[PIN_HRST_N] | cap_r.s2[PIN_HRST];
  assign rq.nmi_edge = cap_r.s3[0] & ~cap_r.s2[PIN_NMI];
  // one line per external request
  assign rq.ext_edge = cap_r.s3[NUM_EDGE-1:1] & ~cap_r.s2[NUM_PINS-1:PIN_EXT];
endmodule
`default_nettype wire

/* hdl/dvi_vectoring.sv */
// interrupt vectoring core: flags, mask, vector fetch sequencing, acknowledge pin
`timescale 1ns/1ps
`default_nettype none
module dvi_vectoring
  import dvi_pkg::*;
#(
  parameter bit P_MASK_ONE_MASKS = 1'b1
)
(
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rstn,
  // reset pins
  input wire logic i_hardware_reset_pin_n,
  input wire logic i_hardware_reset_pin,
  // request pins and timer
  input wire logic i_nmi_n,
  input wire logic i_external_request_a_n,
  input wire logic i_external_request_b_n,
  input wire logic i_external_request_c_n,
  input wire logic i_timer_request,
  // data memory register port
  input wire logic [15:0] i_dm_addr,
  input wire logic i_dm_wr,
  input wire logic i_dm_rd,
  input wire logic [15:0] i_dm_wdata,
  output logic [15:0] o_dm_rdata,
  // cpu core side
  input wire logic i_int_global_en,
  input wire logic i_software_vector_branch_valid,
  input wire logic [4:0] i_software_vector_branch_k,
  output logic o_software_vector_branch_accept,
  input wire logic i_bus_ready,
  output logic o_fetch_active,
  output logic [5:0] o_fetch_addr,
  output logic o_core_reset,
  // acknowledge pin
  output logic o_vector_fetch_acknowledge_n
);
  typedef struct packed {
    dvi_state_t state;
    logic boot_pend;
    logic nmi_pend;
    logic [NUM_MASKABLE-1:0] pend;
    logic [NUM_MASKABLE-1:0] mask;
    logic [5:0] fetch_addr;
    logic [15:0] rdata;
  } dvi_core_t;

  localparam logic [NUM_MASKABLE-1:0] MASK_RST = P_MASK_ONE_MASKS ? 4'hf : 4'h0;
  localparam dvi_core_t CORE_RST = '{
    state: ST_IDLE,
    boot_pend: 1'b1,
    nmi_pend: 1'b0,
    pend: FLAGS_CLEAR,
    mask: MASK_RST,
    fetch_addr: VEC_RESET,
    rdata: RDATA_RESET
  };

  dvi_core_t st_r;
  dvi_core_t st_nxt;

  logic hw_rst;
  logic sel_pend;
  logic sel_mask;
  logic [NUM_MASKABLE-1:0] mask_open;
  logic [NUM_MASKABLE-1:0] set_ev;
  logic [NUM_MASKABLE-1:0] w1c;
  logic [NUM_MASKABLE-1:0] take_clr;
  logic [NUM_MASKABLE-1:0] rd_sel;
  logic launch;
  logic swi_take;
  logic [4:0] launch_k;

  dvi_req_if rq();

  ////////////////////////////////////////////////////////////////////////////
  // request capture and arbitration
  dvi_req_capture u_cap (
    .i_mclk(i_mclk),
    .i_rstn(i_rstn),
    .i_hardware_reset_pin_n(i_hardware_reset_pin_n),
    .i_hardware_reset_pin(i_hardware_reset_pin),
    .i_nmi_n(i_nmi_n),
    .i_ext_req_n({i_external_request_c_n, i_external_request_b_n, i_external_request_a_n}),
    .rq(rq)
  );

  dvi_prio_enc u_prio (
    .rq(rq)
  );

  ////////////////////////////////////////////////////////////////////////////
  // gating and decode
  assign hw_rst = rq.rst_active;
  assign sel_pend = (i_dm_addr == ADDR_PENDING);
  assign sel_mask = (i_dm_addr == ADDR_MASK);
  assign mask_open = P_MASK_ONE_MASKS ? ~st_r.mask : st_r.mask;
  assign rq.enabled = st_r.pend & mask_open & {NUM_MASKABLE{i_int_global_en}};
  assign rq.nmi_pend = st_r.nmi_pend;
  assign rq.boot_pend = st_r.boot_pend;
  assign set_ev = {i_timer_request, rq.ext_edge};
  assign w1c = (i_dm_wr && sel_pend) ? i_dm_wdata[NUM_MASKABLE-1:0] : FLAGS_CLEAR;
  assign rd_sel = sel_pend ? st_r.pend : (sel_mask ? st_r.mask : FLAGS_CLEAR);

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb
  begin
    st_nxt = st_r;
    launch = 1'b0;
    swi_take = 1'b0;
    launch_k = K_RESET;
    take_clr = FLAGS_CLEAR;
    case (st_r.state)
      ST_IDLE:
      begin
        if (rq.pick_valid)
        begin
          launch = 1'b1;
          launch_k = rq.pick_k;
          take_clr = rq.pick_clr;
        end
        else if (i_software_vector_branch_valid)
        begin
          launch = 1'b1;
          launch_k = i_software_vector_branch_k;
          swi_take = 1'b1;
        end
      end
      ST_ACK:
        st_nxt.state = i_bus_ready ? ST_IDLE : ST_HOLD;
      ST_HOLD:
        if (i_bus_ready)
          st_nxt.state = ST_IDLE;
      default:
        st_nxt.state = ST_IDLE;
    endcase
    if (launch)
    begin
      st_nxt.state = ST_ACK;
      st_nxt.fetch_addr = dvi_vec_of(launch_k);
    end
    st_nxt.boot_pend = st_r.boot_pend & ~launch;
    st_nxt.nmi_pend = (st_r.nmi_pend & ~(launch & ~st_r.boot_pend & ~swi_take)) | rq.nmi_edge;
    // a new event beats a clear in the same cycle
    st_nxt.pend = (st_r.pend & ~w1c & ~take_clr) | set_ev;
    if (i_dm_wr && sel_mask)
      st_nxt.mask = i_dm_wdata[NUM_MASKABLE-1:0];
    if (i_dm_rd)
      st_nxt.rdata = {RSVD_ZERO, rd_sel};
    if (hw_rst)
      st_nxt = CORE_RST;
  end

  always_ff @(posedge i_mclk or negedge i_rstn)
  begin
    if (!i_rstn)
      st_r <= CORE_RST;
    else
      st_r <= st_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign o_dm_rdata = st_r.rdata;
  assign o_fetch_active = (st_r.state != ST_IDLE);
  assign o_fetch_addr = st_r.fetch_addr;
  assign o_core_reset = hw_rst;
  assign o_software_vector_branch_accept = swi_take & ~hw_rst;
  assign o_vector_fetch_acknowledge_n = ~(st_r.state == ST_ACK);

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_rstn);

  sequence s_idle_clear;
    st_r.state == ST_IDLE && !hw_rst && !st_r.boot_pend && !st_r.nmi_pend;
  endsequence

  sequence s_fetch(logic [5:0] v);
    !o_vector_fetch_acknowledge_n && o_fetch_addr == v;
  endsequence

  property p_reset_enter;
    hw_rst |=> (st_r.boot_pend && o_vector_fetch_acknowledge_n && st_r.pend == FLAGS_CLEAR);
  endproperty
  a_reset_enter: assert property (p_reset_enter) else $error("reset not entered");

  property p_reset_fetch;
    (st_r.state == ST_IDLE && st_r.boot_pend && !hw_rst) |=> s_fetch(VEC_RESET);
  endproperty
  a_reset_fetch: assert property (p_reset_fetch) else $error("reset fetch wrong");

  property p_ext_a;
    s_idle_clear ##0 rq.enabled[BIT_EXT_A] |=> s_fetch(VEC_EXT_A);
  endproperty
  a_ext_a: assert property (p_ext_a) else $error("line a vector wrong");

  property p_ext_b;
    s_idle_clear ##0 (rq.enabled[BIT_EXT_B] && !rq.enabled[BIT_EXT_A]) |=> s_fetch(VEC_EXT_B);
  endproperty
  a_ext_b: assert property (p_ext_b) else $error("line b vector wrong");

  property p_ext_c;
    s_idle_clear ##0 (rq.enabled == (4'h1 << BIT_EXT_C)) |=> s_fetch(VEC_EXT_C);
  endproperty
  a_ext_c: assert property (p_ext_c) else $error("line c vector wrong");

  property p_timer;
    s_idle_clear ##0 (rq.enabled == (4'h1 << BIT_TIMER)) |=> s_fetch(VEC_TIMER);
  endproperty
  a_timer: assert property (p_timer) else $error("timer vector wrong");

  property p_nmi;
    (st_r.state == ST_IDLE && !hw_rst && !st_r.boot_pend && st_r.nmi_pend) |=> s_fetch(VEC_NMI);
  endproperty
  a_nmi: assert property (p_nmi) else $error("nmi vector wrong");

  property p_trap;
    s_idle_clear ##0 (!rq.pick_valid && i_software_vector_branch_valid &&
      i_software_vector_branch_k == K_TRAP) |-> o_software_vector_branch_accept ##1 s_fetch(VEC_TRAP);
  endproperty
  a_trap: assert property (p_trap) else $error("trap vector wrong");

  property p_ack_one;
    !o_vector_fetch_acknowledge_n |=> o_vector_fetch_acknowledge_n;
  endproperty
  a_ack_one: assert property (p_ack_one) else $error("acknowledge stretched");

  property p_ack_wait;
    (!o_vector_fetch_acknowledge_n && !i_bus_ready && !hw_rst) |=>
      (o_vector_fetch_acknowledge_n && o_fetch_active && $stable(o_fetch_addr));
  endproperty
  a_ack_wait: assert property (p_ack_wait) else $error("wait handling wrong");

  property p_w1c;
    (i_dm_wr && sel_pend && i_dm_wdata[BIT_EXT_A] && !set_ev[BIT_EXT_A]) |=> !st_r.pend[BIT_EXT_A];
  endproperty
  a_w1c: assert property (p_w1c) else $error("flag not cleared");

  property p_w0_keep;
    (i_dm_wr && sel_pend && !i_dm_wdata[BIT_TIMER] && st_r.pend[BIT_TIMER] &&
      !take_clr[BIT_TIMER] && !hw_rst) |=> st_r.pend[BIT_TIMER];
  endproperty
  a_w0_keep: assert property (p_w0_keep) else $error("flag lost on zero write");

  property p_set_wins;
    (set_ev[BIT_EXT_C] && !hw_rst) |=> st_r.pend[BIT_EXT_C];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("event lost");

  property p_rsvd_zero;
    o_dm_rdata[15:NUM_MASKABLE] == RSVD_ZERO;
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bits set");

  property p_masked;
    s_idle_clear ##0 (!i_software_vector_branch_valid && (st_r.pend & mask_open) == FLAGS_CLEAR)
      |=> o_vector_fetch_acknowledge_n;
  endproperty
  a_masked: assert property (p_masked) else $error("masked request taken");

  property p_prio;
    s_idle_clear ##0 (rq.enabled[BIT_EXT_A] && rq.enabled[BIT_TIMER] && !w1c[BIT_TIMER] &&
      !set_ev[BIT_EXT_A]) |=> s_fetch(VEC_EXT_A) ##0 (!st_r.pend[BIT_EXT_A] && st_r.pend[BIT_TIMER]);
  endproperty
  a_prio: assert property (p_prio) else $error("priority order wrong");

  property p_global_off;
    s_idle_clear ##0 (!i_int_global_en && !i_software_vector_branch_valid) |=>
      o_vector_fetch_acknowledge_n;
  endproperty
  a_global_off: assert property (p_global_off) else $error("disabled request taken");

  property p_read_mask;
    (i_dm_rd && sel_mask && !hw_rst) |=> o_dm_rdata == {RSVD_ZERO, $past(st_r.mask)};
  endproperty
  a_read_mask: assert property (p_read_mask) else $error("mask read wrong");

  property p_swi_low;
    (st_r.state == ST_IDLE && rq.pick_valid) |-> !o_software_vector_branch_accept;
  endproperty
  a_swi_low: assert property (p_swi_low) else $error("branch beat hardware");
endmodule
`default_nettype wire

/* shared/dvi_pkg.sv */
// constants, state type and vector helper for the interrupt vectoring block
`default_nettype none
package dvi_pkg;
  localparam int NUM_MASKABLE = 4;
  localparam int NUM_PINS = 6;
  localparam int NUM_EDGE = 4;
  // flag and mask bit positions
  localparam int BIT_EXT_A = 0;
  localparam int BIT_EXT_B = 1;
  localparam int BIT_EXT_C = 2;
  localparam int BIT_TIMER = 3;
  // synchroniser lanes
  localparam int PIN_HRST_N = 0;
  localparam int PIN_HRST = 1;
  localparam int PIN_NMI = 2;
  localparam int PIN_EXT = 3;
  localparam logic [NUM_PINS-1:0] PIN_IDLE = 6'h3d;
  localparam logic [NUM_EDGE-1:0] EDGE_IDLE = 4'hf;
  // branch operands
  localparam logic [4:0] K_RESET = 5'h00;
  localparam logic [4:0] K_EXT_A = 5'h01;
  localparam logic [4:0] K_EXT_B = 5'h02;
  localparam logic [4:0] K_EXT_C = 5'h03;
  localparam logic [4:0] K_TIMER = 5'h04;
  localparam logic [4:0] K_TRAP = 5'h11;
  localparam logic [4:0] K_NMI = 5'h12;
  // vector locations
  localparam logic [5:0] VEC_RESET = 6'h00;
  localparam logic [5:0] VEC_EXT_A = 6'h02;
  localparam logic [5:0] VEC_EXT_B = 6'h04;
  localparam logic [5:0] VEC_EXT_C = 6'h06;
  localparam logic [5:0] VEC_TIMER = 6'h08;
  localparam logic [5:0] VEC_TRAP = 6'h22;
  localparam logic [5:0] VEC_NMI = 6'h24;
  // register word addresses
  localparam logic [15:0] ADDR_PENDING = 16'h0006;
  localparam logic [15:0] ADDR_MASK = 16'h0004;
  localparam logic [11:0] RSVD_ZERO = 12'h000;
  localparam logic [3:0] FLAGS_CLEAR = 4'h0;
  localparam logic [15:0] RDATA_RESET = 16'h0000;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_ACK = 2'h1,
    ST_HOLD = 2'h3
  } dvi_state_t;

  // vectors sit two words apart
  function automatic logic [5:0] dvi_vec_of(input logic [4:0] k);
    return {k, 1'b0};
  endfunction
endpackage
`default_nettype wire

/* shared/dvi_req_if.sv */
// request and selection signals between capture, arbiter and core
`timescale 1ns/1ps
`default_nettype none
interface dvi_req_if;
  logic [2:0] ext_edge;
  logic nmi_edge;
  logic rst_active;
  logic [3:0] enabled;
  logic nmi_pend;
  logic boot_pend;
  logic pick_valid;
  logic [4:0] pick_k;
  logic [3:0] pick_clr;
  modport cap (output ext_edge, nmi_edge, rst_active);
  modport core (
    input ext_edge, nmi_edge, rst_active, pick_valid, pick_k, pick_clr,
    output enabled, nmi_pend, boot_pend
  );
  modport prio (input enabled, nmi_pend, boot_pend, output pick_valid, pick_k, pick_clr);
endinterface
`default_nettype wire

/* verification/dvi_source_model.sv */
// far-side model: request pin drivers and acknowledge decoder
`timescale 1ns/1ps
`default_nettype none
module dvi_source_model
(
  // clock
  input wire logic i_mclk,
  // bench commands: bits 2..0 lines c b a, bit 3 nmi
  input wire logic [3:0] i_fire,
  // acknowledge side
  input wire logic i_ack_n,
  input wire logic [5:0] i_addr,
  // pins and decode result
  output logic [3:0] o_pin_n,
  output logic [3:0] o_seen
);
  logic [2:0] cnt_r [4] = '{default: 3'h0};
  logic ack_q_r = 1'b1;
  ////////////////////////////////////////////////////////////
  // pin held low a few cycles per command, idle high
  always @(posedge i_mclk)
  begin
    for (int i = 0; i < 4; i++)
    begin
      if (i_fire[i])
        cnt_r[i] <= 3'h4;
      else if (cnt_r[i] != 3'h0)
        cnt_r[i] <= cnt_r[i] - 3'h1;
    end
    ack_q_r <= i_ack_n;
    if (ack_q_r && !i_ack_n)
      o_seen <= i_addr[4:1];
  end
  always_comb
  begin
    for (int i = 0; i < 4; i++)
      o_pin_n[i] = (cnt_r[i] == 3'h0);
  end
endmodule
`default_nettype wire

/* verification/test_dsp_interrupt_vectoring.sv */
// self-checking bench for the interrupt vectoring block
`timescale 1ns/1ps
`default_nettype none
module test_dsp_interrupt_vectoring;
  import dvi_pkg::*;
  typedef struct packed {logic [3:0] fire; logic tmr; logic [5:0] vec;} dvi_row_t;
  logic i_mclk, i_rstn, rs_n, rs, tmr, wr, rd, ready, sw_v, accept, fetch, core_rst, ack_n, gie;
  logic [15:0] addr, wdata, rdata;
  logic [4:0] sw_k;
  logic [5:0] faddr;
  logic [3:0] fire, pin_n, seen;
  int failures, n_checks;
  dvi_row_t rows [5] = '{{4'h1, 1'b0, 6'h02}, {4'h2, 1'b0, 6'h04}, {4'h4, 1'b0, 6'h06},
    {4'h0, 1'b1, 6'h08}, {4'h8, 1'b0, 6'h24}};
  ////////////////////////////////////////////////////////////
  dvi_vectoring dut (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_hardware_reset_pin_n(rs_n),
    .i_hardware_reset_pin(rs), .i_nmi_n(pin_n[3]), .i_external_request_a_n(pin_n[0]),
    .i_external_request_b_n(pin_n[1]), .i_external_request_c_n(pin_n[2]),
    .i_timer_request(tmr), .i_dm_addr(addr), .i_dm_wr(wr), .i_dm_rd(rd),
    .i_dm_wdata(wdata), .o_dm_rdata(rdata), .i_int_global_en(gie),
    .i_software_vector_branch_valid(sw_v), .i_software_vector_branch_k(sw_k),
    .o_software_vector_branch_accept(accept), .i_bus_ready(ready),
    .o_fetch_active(fetch), .o_fetch_addr(faddr), .o_core_reset(core_rst),
    .o_vector_fetch_acknowledge_n(ack_n));
  dvi_source_model src (.i_mclk(i_mclk), .i_fire(fire), .i_ack_n(ack_n), .i_addr(faddr),
    .o_pin_n(pin_n), .o_seen(seen));
  initial
  begin
    i_mclk = 1'b0;
    forever #10 i_mclk = ~i_mclk;
  end
  ////////////////////////////////////////////////////////////
  task automatic end_sim();
    if (failures == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic check(input logic ok, input string m);
    n_checks++;
    if (ok !== 1'b1)
    begin
      failures++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask
  task automatic wr_reg(input logic [15:0] a, input logic [15:0] d);
    @(posedge i_mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge i_mclk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [15:0] a, input logic [15:0] exp);
    @(posedge i_mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge i_mclk);
    rd <= 1'b0;
    @(posedge i_mclk);
    check(rdata === exp, "register read value");
  endtask
  // wait for acknowledge, check vector, width and far-side decode
  task automatic wait_ack(input logic [5:0] exp);
    int n;
    for (n = 0; n < 40; n++)
    begin
      @(posedge i_mclk);
      if (ack_n === 1'b0)
        break;
    end
    if (n == 40)
    begin
      check(1'b0, "no acknowledge");
      end_sim();
    end
    check(faddr === exp, "vector address");
    @(posedge i_mclk);
    check(ack_n === 1'b1, "acknowledge longer than one cycle");
    check(seen === exp[4:1], "decoded vector bits");
  endtask
  task automatic sw_branch(input logic [4:0] k, input logic [5:0] exp);
    int n;
    @(posedge i_mclk);
    sw_v <= 1'b1;
    sw_k <= k;
    for (n = 0; n < 40; n++)
    begin
      @(posedge i_mclk);
      if (accept === 1'b1)
        break;
    end
    sw_v <= 1'b0;
    if (n == 40)
    begin
      check(1'b0, "branch not accepted");
      end_sim();
    end
    wait_ack(exp);
  endtask
  ////////////////////////////////////////////////////////////
  initial
  begin
    failures = 0;
    n_checks = 0;
    i_rstn = 1'b0;
    {rs, tmr, wr, rd, sw_v} = 5'h0;
    rs_n = 1'b1;
    gie = 1'b1;
    ready = 1'b1;
    addr = 16'h0000;
    wdata = 16'h0000;
    sw_k = 5'h00;
    fire = 4'h0;
    repeat (5) @(posedge i_mclk);
    i_rstn <= 1'b1;
    wait_ack(VEC_RESET);
    rd_reg(ADDR_PENDING, 16'h0000);
    rd_reg(ADDR_MASK, 16'h000f);
    // masked requests stay pending
    @(posedge i_mclk);
    fire <= 4'h7;
    tmr <= 1'b1;
    @(posedge i_mclk);
    fire <= 4'h0;
    tmr <= 1'b0;
    repeat (8) @(posedge i_mclk);
    rd_reg(ADDR_PENDING, 16'h000f);
    wr_reg(ADDR_PENDING, 16'hfff5);
    rd_reg(ADDR_PENDING, 16'h000a);
    wr_reg(ADDR_PENDING, 16'hfff0);
    rd_reg(ADDR_PENDING, 16'h000a);
    rd_reg(16'h0010, 16'h0000);
    // line a again while masked, global disable holds all three
    @(posedge i_mclk);
    fire <= 4'h1;
    gie <= 1'b0;
    @(posedge i_mclk);
    fire <= 4'h0;
    repeat (8) @(posedge i_mclk);
    wr_reg(ADDR_MASK, 16'hfff0);
    rd_reg(ADDR_PENDING, 16'h000b);
    @(posedge i_mclk);
    gie <= 1'b1;
    wait_ack(VEC_EXT_A);
    wait_ack(VEC_EXT_B);
    wait_ack(VEC_TIMER);
    rd_reg(ADDR_MASK, 16'h0000);
    rd_reg(ADDR_PENDING, 16'h0000);
    // one row per hardware source other than reset
    foreach (rows[i])
    begin
      @(posedge i_mclk);
      fire <= rows[i].fire;
      tmr <= rows[i].tmr;
      @(posedge i_mclk);
      fire <= 4'h0;
      tmr <= 1'b0;
      wait_ack(rows[i].vec);
    end
    // software branches, the first with wait states, the second without
    ready <= 1'b0;
    sw_branch(K_TRAP, VEC_TRAP);
    check(fetch === 1'b1, "fetch ended under wait state");
    @(posedge i_mclk);
    ready <= 1'b1;
    sw_branch(5'h1f, 6'h3e);
    // both reset pins
    for (int p = 0; p < 2; p++)
    begin
      @(posedge i_mclk);
      rs_n <= (p != 0);
      rs <= (p != 0);
      repeat (4) @(posedge i_mclk);
      check(core_rst === 1'b1, "pin reset not seen");
      rs_n <= 1'b1;
      rs <= 1'b0;
      wait_ack(VEC_RESET);
    end
    end_sim();
  end
endmodule
`default_nettype wire
